// File: src/gvc_pkg.sv
package gvc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_OUT_VALUES = 8'h29;
    localparam logic [7:0] IDX_MONITOR = 8'h2A;
    localparam logic [7:0] IDX_SEL_A = 8'h2B;
    localparam logic [7:0] IDX_SEL_B = 8'h2C;
    // bidir pin config register, offset of our own
    localparam logic [7:0] IDX_BIDIR_CFG = 8'h21;
    // output pin config registers for pins one..four, offsets of our own
    localparam logic [7:0] IDX_OUT_CFG0 = 8'h22;
    localparam int NUM_OUT = 4;
    localparam int BIT_BIDIR_VAL = 7;
    localparam int BIT_MON = 7;
    localparam logic [7:0] VAL_MASK = 8'hF8;
    localparam logic [7:0] SEL_MASK = 8'h77;
    localparam logic [7:0] CFG_MASK = 8'hF7;
    localparam int SEL_HI_POS = 4;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [3:0] OUT_FN_GPO = 4'h1;
    // bidir pin function field: 0 off, 1 input, 2 output
    localparam logic [3:0] BIDIR_FN_GPI = 4'h1;
    localparam logic [3:0] BIDIR_FN_GPO = 4'h2;

    typedef enum logic [2:0] {
        FN_OFF, FN_GPI, FN_MCLK, FN_CHAIN_IN, FN_PDM_A, FN_PDM_B, FN_PDM_C, FN_PDM_D
    } gvc_in_fn_t;

    typedef enum logic [2:0] {
        DRV_HIZ, DRV_PUSH_PULL, DRV_LOW_WEAK_HIGH, DRV_LOW_HIZ, DRV_WEAK_LOW_HIGH, DRV_HIZ_HIGH,
        DRV_RSV6, DRV_RSV7
    } gvc_drv_t;
endpackage

// File: src/gvc_pin_drive.sv
`timescale 1ns/1ps
module gvc_pin_drive
    import gvc_pkg::*;
(
    input wire logic enable,
    input wire logic value,
    input wire logic [2:0] mode,
    output logic pin_o,
    output logic pin_oe,
    output logic pin_weak
);
    // purely combinational; the top registers the results
    always_comb begin
        pin_o = value;
        pin_oe = 1'b0;
        pin_weak = 1'b0;
        if (enable) begin
            unique case (gvc_drv_t'(mode))
                DRV_PUSH_PULL: begin
                    pin_oe = 1'b1;
                end
                DRV_LOW_WEAK_HIGH: begin
                    pin_oe = 1'b1;
                    pin_weak = value;
                end
                DRV_LOW_HIZ: begin
                    pin_oe = ~value;
                end
                DRV_WEAK_LOW_HIGH: begin
                    pin_oe = 1'b1;
                    pin_weak = ~value;
                end
                DRV_HIZ_HIGH: begin
                    pin_oe = value;
                end
                default: begin
                    pin_oe = 1'b0;
                end
            endcase
        end
    end
endmodule

// File: src/gvc_in_route.sv
`timescale 1ns/1ps
module gvc_in_route
    import gvc_pkg::*;
#(
    parameter int NUM_IN = 4
)(
    input wire logic [NUM_IN-1:0] pin_i,
    input wire logic [3*NUM_IN-1:0] sel,
    output logic [NUM_IN-1:0] gpi_level,
    output logic mclk_in,
    output logic chain_in,
    output logic [3:0] pdm_in
);
    // lowest pin wins if software selects one function on two pins
    always_comb begin
        gpi_level = '0;
        mclk_in = 1'b0;
        chain_in = 1'b0;
        pdm_in = '0;
        for (int i = NUM_IN - 1; i >= 0; i--) begin
            unique case (gvc_in_fn_t'(sel[3*i +: 3]))
                FN_OFF: begin
                end
                FN_GPI: gpi_level[i] = pin_i[i];
                FN_MCLK: mclk_in = pin_i[i];
                FN_CHAIN_IN: chain_in = pin_i[i];
                FN_PDM_A: pdm_in[0] = pin_i[i];
                FN_PDM_B: pdm_in[1] = pin_i[i];
                FN_PDM_C: pdm_in[2] = pin_i[i];
                FN_PDM_D: pdm_in[3] = pin_i[i];
            endcase
        end
    end
endmodule

// File: src/gvc_top.sv
`timescale 1ns/1ps
module gvc_top
    import gvc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bidir_general_pin_i,
    output logic bidir_general_pin_o,
    output logic bidir_general_pin_oe,
    output logic bidir_general_pin_weak,
    output logic [3:0] output_pin_o,
    output logic [3:0] output_pin_oe,
    output logic [3:0] output_pin_weak,
    input wire logic [3:0] input_pin_i,
    output logic [3:0] gpi_level,
    output logic master_clock_in,
    output logic daisy_chain_serial_in,
    output logic [3:0] pdm_data_in
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] out_values;
        logic [7:0] monitor;
        logic [7:0] sel_a;
        logic [7:0] sel_b;
        logic [7:0] bidir_cfg;
        logic [3:0][7:0] out_cfg;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic bd_o;
        logic bd_oe;
        logic bd_weak;
        logic [3:0] op_o;
        logic [3:0] op_oe;
        logic [3:0] op_weak;
        logic [3:0] gpi;
        logic mclk;
        logic chain;
        logic [3:0] pdm;
    } gvc_state_t;

    gvc_state_t st;
    gvc_state_t next_st;

    logic [7:0] idx;
    logic access;
    logic hit;
    logic [3:0] rt_gpi;
    logic rt_mclk;
    logic rt_chain;
    logic [3:0] rt_pdm;
    logic [4:0] drv_o;
    logic [4:0] drv_oe;
    logic [4:0] drv_weak;
    logic [4:0] drv_en;
    logic [4:0] drv_val;
    logic [4:0][2:0] drv_mode;

    function automatic logic is_out_cfg(input logic [7:0] a);
        return (a >= IDX_OUT_CFG0) && (a < IDX_OUT_CFG0 + 8'(NUM_OUT));
    endfunction

    assign idx = paddr[9:2];
    // one wait-free access phase; unaligned addresses are unmapped
    assign access = psel && penable;
    assign hit = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
        (idx == IDX_OUT_VALUES || idx == IDX_MONITOR || idx == IDX_SEL_A ||
        idx == IDX_SEL_B || idx == IDX_BIDIR_CFG || is_out_cfg(idx));

    ////////////////////////////////////////////////////////////////////////////////
    gvc_in_route #(
        .NUM_IN(4)
    ) u_route (
        .pin_i(input_pin_i),
        .sel({st.sel_b[2:0], st.sel_b[6:4], st.sel_a[2:0], st.sel_a[6:4]}),
        .gpi_level(rt_gpi),
        .mclk_in(rt_mclk),
        .chain_in(rt_chain),
        .pdm_in(rt_pdm)
    );

    // index 4 is the two-way pin, always push-pull when it is an output
    assign drv_en[4] = st.bidir_cfg[7:4] == BIDIR_FN_GPO;
    assign drv_val[4] = st.out_values[BIT_BIDIR_VAL];
    assign drv_mode[4] = DRV_PUSH_PULL;

    for (genvar g = 0; g < NUM_OUT; g++) begin : g_drv
        assign drv_en[g] = st.out_cfg[g][7:4] == OUT_FN_GPO;
        assign drv_val[g] = st.out_values[6 - g];
        assign drv_mode[g] = st.out_cfg[g][2:0];
    end

    for (genvar g = 0; g < 5; g++) begin : g_pin
        gvc_pin_drive u_drv (
            .enable(drv_en[g]),
            .value(drv_val[g]),
            .mode(drv_mode[g]),
            .pin_o(drv_o[g]),
            .pin_oe(drv_oe[g]),
            .pin_weak(drv_weak[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.ready = 1'b0;
        next_st.err = 1'b0;
        if (psel && !penable) begin
            next_st.ready = 1'b1;
            next_st.err = !hit;
            next_st.rdata = '0;
            if (!pwrite && hit) begin
                if (idx == IDX_OUT_VALUES) next_st.rdata[7:0] = st.out_values;
                if (idx == IDX_MONITOR) next_st.rdata[7:0] = st.monitor;
                if (idx == IDX_SEL_A) next_st.rdata[7:0] = st.sel_a;
                if (idx == IDX_SEL_B) next_st.rdata[7:0] = st.sel_b;
                if (idx == IDX_BIDIR_CFG) next_st.rdata[7:0] = st.bidir_cfg;
                if (is_out_cfg(idx)) begin
                    next_st.rdata[7:0] = st.out_cfg[2'(idx - IDX_OUT_CFG0)];
                end
            end
        end
        if (access && pwrite && hit) begin
            // value bits are stored regardless of pin function
            if (idx == IDX_OUT_VALUES) next_st.out_values = pwdata[7:0] & VAL_MASK;
            if (idx == IDX_SEL_A) next_st.sel_a = pwdata[7:0] & SEL_MASK;
            if (idx == IDX_SEL_B) next_st.sel_b = pwdata[7:0] & SEL_MASK;
            if (idx == IDX_BIDIR_CFG) next_st.bidir_cfg = pwdata[7:0] & 8'hF0;
            if (is_out_cfg(idx)) begin
                next_st.out_cfg[2'(idx - IDX_OUT_CFG0)] = pwdata[7:0] & CFG_MASK;
            end
        end
        // monitor follows pin only in input mode, else holds last level
        if (st.bidir_cfg[7:4] == BIDIR_FN_GPI) begin
            next_st.monitor = {bidir_general_pin_i, 7'h00};
        end
        next_st.bd_o = drv_o[4];
        next_st.bd_oe = drv_oe[4];
        next_st.bd_weak = drv_weak[4];
        next_st.op_o = drv_o[3:0];
        next_st.op_oe = drv_oe[3:0];
        next_st.op_weak = drv_weak[3:0];
        next_st.gpi = rt_gpi;
        next_st.mclk = rt_mclk;
        next_st.chain = rt_chain;
        next_st.pdm = rt_pdm;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;
    assign bidir_general_pin_o = st.bd_o;
    assign bidir_general_pin_oe = st.bd_oe;
    assign bidir_general_pin_weak = st.bd_weak;
    assign output_pin_o = st.op_o;
    assign output_pin_oe = st.op_oe;
    assign output_pin_weak = st.op_weak;
    assign gpi_level = st.gpi;
    assign master_clock_in = st.mclk;
    assign daisy_chain_serial_in = st.chain;
    assign pdm_data_in = st.pdm;

    ////////////////////////////////////////////////////////////////////////////////
    sequence wr_val_s;
        access && pwrite && pready && paddr == {2'b00, IDX_OUT_VALUES, 2'b00};
    endsequence

    bidir_value_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.bidir_cfg[7:4] == BIDIR_FN_GPO) |=> bidir_general_pin_oe &&
        bidir_general_pin_o == $past(st.out_values[7]))
        else $error("bidir pin value wrong");
    pin_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.out_cfg[0][7:4] == OUT_FN_GPO && st.out_cfg[0][2:0] == 3'h1)
        |=> output_pin_o[0] == $past(st.out_values[6]) && output_pin_oe[0])
        else $error("pin one value wrong");
    pin_four_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.out_cfg[3][7:4] == OUT_FN_GPO && st.out_cfg[3][2:0] == 3'h1)
        |=> output_pin_o[3] == $past(st.out_values[3]))
        else $error("pin four value wrong");
    val_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_val_s |=> st.out_values == ($past(pwdata[7:0]) & 8'hF8))
        else $error("value write lost");
    mon_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.monitor[6:0] == 7'h00 && st.sel_a[7] == 1'b0 && st.sel_a[3] == 1'b0)
        else $error("reserved bits set");
    gated_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.out_cfg[1][7:4] != OUT_FN_GPO) |=> !output_pin_oe[1])
        else $error("pin driven when not gpo");
    mclk_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel_a[6:4] == 3'h2 && st.sel_a[2:0] != 3'h2 && st.sel_b[6:4] != 3'h2 &&
        st.sel_b[2:0] != 3'h2) |=> master_clock_in == $past(input_pin_i[0]))
        else $error("mclk route wrong");
    pdm_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel_b[2:0] == 3'h7 && st.sel_a[6:4] != 3'h7 && st.sel_a[2:0] != 3'h7 &&
        st.sel_b[6:4] != 3'h7) |=> pdm_data_in[3] == $past(input_pin_i[3]))
        else $error("pdm route wrong");
    hold_val_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(access && pwrite) |=> $stable(st.out_values))
        else $error("value bits changed");

    // pin one always wins a shared function, so route checks lean on it
    sequence setup_s;
        psel && !penable;
    endsequence

    sequence wr_sel_a_s;
        access && pwrite && pready && paddr == {2'b00, IDX_SEL_A, 2'b00};
    endsequence

    sequence wr_sel_b_s;
        access && pwrite && pready && paddr == {2'b00, IDX_SEL_B, 2'b00};
    endsequence

    sequence mon_input_s;
        st.bidir_cfg[7:4] == BIDIR_FN_GPI;
    endsequence

    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup_s |=> pready ##1 !pready)
        else $error("ready not a single pulse");
    unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !hit) |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    val_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == {2'b00, IDX_OUT_VALUES, 2'b00})
        |=> prdata == {24'h000000, $past(st.out_values)})
        else $error("value read wrong");
    val_rsv_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.out_values[2:0] == 3'h0)
        else $error("value reserved bits set");
    mon_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == {2'b00, IDX_MONITOR, 2'b00})
        |=> prdata == {24'h000000, $past(st.monitor)})
        else $error("monitor read wrong");
    mon_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        mon_input_s |=> st.monitor[7] == $past(bidir_general_pin_i))
        else $error("monitor misses pin level");
    mon_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.bidir_cfg[7:4] != BIDIR_FN_GPI) |=> $stable(st.monitor))
        else $error("monitor moved outside input mode");
    sel_a_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_sel_a_s |=> st.sel_a == ($past(pwdata[7:0]) & SEL_MASK))
        else $error("select a write lost");
    sel_a_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == {2'b00, IDX_SEL_A, 2'b00})
        |=> prdata == {24'h000000, $past(st.sel_a)})
        else $error("select a read wrong");
    sel_b_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_sel_b_s |=> st.sel_b == ($past(pwdata[7:0]) & SEL_MASK))
        else $error("select b write lost");
    sel_b_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == {2'b00, IDX_SEL_B, 2'b00})
        |=> prdata == {24'h000000, $past(st.sel_b)})
        else $error("select b read wrong");
    sel_b_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.sel_b[7] == 1'b0 && st.sel_b[3] == 1'b0)
        else $error("select b reserved bits set");
    gpi_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel_a[2:0] == 3'h1) |=> gpi_level[1] == $past(input_pin_i[1]))
        else $error("general input route wrong");
    off_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel_a[6:4] == 3'h0) |=> !gpi_level[0])
        else $error("disabled pin still routed");
    mclk_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel_a[6:4] != 3'h2 && st.sel_a[2:0] != 3'h2 && st.sel_b[6:4] != 3'h2 &&
        st.sel_b[2:0] != 3'h2) |=> !master_clock_in)
        else $error("clock input without source");
    chain_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel_a[6:4] == 3'h3) |=> daisy_chain_serial_in == $past(input_pin_i[0]))
        else $error("chain input route wrong");
    pdm_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel_a[6:4] == 3'h4) |=> pdm_data_in[0] == $past(input_pin_i[0]))
        else $error("pdm pair route wrong");
    pin_two_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.out_cfg[1][7:4] == OUT_FN_GPO && st.out_cfg[1][2:0] == 3'h1)
        |=> output_pin_o[1] == $past(st.out_values[5]) && output_pin_oe[1])
        else $error("pin two value wrong");
    pin_three_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.out_cfg[2][7:4] == OUT_FN_GPO && st.out_cfg[2][2:0] == 3'h1)
        |=> output_pin_o[2] == $past(st.out_values[4]) && output_pin_oe[2])
        else $error("pin three value wrong");
    bidir_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.bidir_cfg[7:4] != BIDIR_FN_GPO) |=> !bidir_general_pin_oe)
        else $error("two-way pin driven when not output");
    hiz_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.out_cfg[0][2:0] == 3'h0) |=> !output_pin_oe[0])
        else $error("hi-z mode drives");
    weak_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.out_cfg[0][7:4] == OUT_FN_GPO && st.out_cfg[0][2:0] == 3'h2)
        |=> output_pin_oe[0] && output_pin_weak[0] == $past(st.out_values[6]))
        else $error("weak high mode wrong");
    low_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.out_cfg[0][7:4] == OUT_FN_GPO && st.out_cfg[0][2:0] == 3'h3)
        |=> output_pin_oe[0] == !$past(st.out_values[6]))
        else $error("low hi-z mode wrong");
    weak_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.out_cfg[0][7:4] == OUT_FN_GPO && st.out_cfg[0][2:0] == 3'h4)
        |=> output_pin_oe[0] && output_pin_weak[0] == !$past(st.out_values[6]))
        else $error("weak low mode wrong");
    hiz_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.out_cfg[0][7:4] == OUT_FN_GPO && st.out_cfg[0][2:0] == 3'h5)
        |=> output_pin_oe[0] == $past(st.out_values[6]))
        else $error("hi-z high mode wrong");
    rsv_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.out_cfg[0][2:1] == 2'b11) |=> !output_pin_oe[0])
        else $error("reserved mode drives");
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import gvc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, bidir_general_pin_i = 1'b0;
    logic bidir_general_pin_o, bidir_general_pin_oe, bidir_general_pin_weak;
    logic [3:0] output_pin_o, output_pin_oe, output_pin_weak, gpi_level, pdm_data_in;
    logic [3:0] input_pin_i = 4'h0;
    logic master_clock_in, daisy_chain_serial_in;
    logic [15:0] rnd = 16'hE6EF;
    logic [31:0] rdv;
    logic [11:0] s;
    logic [7:0] v;
    logic e;
    int fails = 0, samples_checked = 0;
    always #5 pclk = ~pclk;
    gvc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bidir_general_pin_i(bidir_general_pin_i),
        .bidir_general_pin_o(bidir_general_pin_o), .bidir_general_pin_oe(bidir_general_pin_oe),
        .bidir_general_pin_weak(bidir_general_pin_weak), .output_pin_o(output_pin_o),
        .output_pin_oe(output_pin_oe), .output_pin_weak(output_pin_weak),
        .input_pin_i(input_pin_i), .gpi_level(gpi_level), .master_clock_in(master_clock_in),
        .daisy_chain_serial_in(daisy_chain_serial_in), .pdm_data_in(pdm_data_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
    // lowest pin wins a shared function, so walk from pin four down
    function automatic logic [9:0] exp_route(input logic [11:0] sl, input logic [3:0] in);
        logic [3:0] g, p;
        logic m, d;
        {g, p, m, d} = 10'h000;
        for (int k = 3; k >= 0; k--) begin
            case (sl[3*k +: 3])
                3'h1: g[k] = in[k];
                3'h2: m = in[k];
                3'h3: d = in[k];
                3'h0: ;
                default: p[sl[3*k +: 2]] = in[k];
            endcase
        end
        return {g, m, d, p};
    endfunction
    // returns {oe, o, weak}; modes 6-7 stay hi-z
    function automatic logic [2:0] exp_drv(input logic [2:0] md, input logic b);
        case (md)
            3'h1: return {1'b1, b, 1'b0};
            3'h2: return {1'b1, b, b};
            3'h3: return {~b, 1'b0, 1'b0};
            3'h4: return {1'b1, b, ~b};
            3'h5: return {b, b, 1'b0};
            default: return 3'h0;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {rnd, 8'hA5, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, rdv, e);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] x, input logic xe);
        apb(1'b0, a, 8'h00, rdv, e);
        check(rdv, {24'h000000, x});
        check({31'h0, e}, {31'h0, xe});
    endtask
    // outputs are registered one edge behind the write
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ad(IDX_OUT_VALUES), 8'h00, 1'b0);
        rdc(ad(IDX_MONITOR), 8'h00, 1'b0);
        rdc(ad(IDX_SEL_A), 8'h00, 1'b0);
        rdc(ad(IDX_SEL_B), 8'h00, 1'b0);
        check({output_pin_oe, bidir_general_pin_oe}, 5'h00);
        $display("done: reset values");
        wr(ad(IDX_SEL_A), 8'hFF);
        rdc(ad(IDX_SEL_A), 8'h77, 1'b0);
        wr(ad(IDX_SEL_B), 8'hFF);
        rdc(ad(IDX_SEL_B), 8'h77, 1'b0);
        wr(ad(IDX_OUT_VALUES), 8'hFF);
        rdc(ad(IDX_OUT_VALUES), 8'hF8, 1'b0);
        wr(ad(IDX_MONITOR), 8'hFF);
        rdc(ad(IDX_MONITOR), 8'h00, 1'b0);
        rdc(12'h000, 8'h00, 1'b1);
        rdc(ad(IDX_OUT_VALUES) + 12'h001, 8'h00, 1'b1);
        $display("done: register access");
        wr(ad(IDX_BIDIR_CFG), 8'h20);
        for (int k = 0; k < NUM_OUT; k++) wr(ad(IDX_OUT_CFG0 + 8'(k)), 8'h11);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            v = (i == 0) ? 8'hF8 : rnd[7:0] & VAL_MASK;
            wr(ad(IDX_OUT_VALUES), (i == 0) ? 8'hFF : rnd[7:0]);
            settle();
            check({output_pin_oe, output_pin_o}, {4'hF, v[3], v[4], v[5], v[6]});
            check({bidir_general_pin_oe, bidir_general_pin_o}, {1'b1, v[7]});
            check(bidir_general_pin_weak, 1'b0);
            check(output_pin_weak, 4'h0);
            rdc(ad(IDX_OUT_VALUES), v & VAL_MASK, 1'b0);
        end
        $display("done: output values");
        // leaving gpo must free the pins yet keep the stored values
        wr(ad(IDX_OUT_VALUES), 8'hF8);
        wr(ad(IDX_OUT_CFG0 + 8'h01), 8'h01);
        wr(ad(IDX_BIDIR_CFG), 8'h10);
        settle();
        check({output_pin_oe, bidir_general_pin_oe}, 5'h1A);
        wr(ad(IDX_OUT_CFG0 + 8'h01), 8'h11);
        wr(ad(IDX_BIDIR_CFG), 8'h20);
        settle();
        check({output_pin_o, bidir_general_pin_o}, 5'h1F);
        $display("done: function hand-over");
        for (int m = 0; m < 16; m++) begin
            wr(ad(IDX_OUT_CFG0), {4'h1, 1'b0, 3'(m)});
            wr(ad(IDX_OUT_VALUES), {1'b0, m[3], 6'h00});
            settle();
            v[2:0] = exp_drv(3'(m), m[3]);
            check(output_pin_oe[0], v[2]);
            if (v[2]) check({output_pin_o[0], output_pin_weak[0]}, v[1:0]);
        end
        $display("done: drive modes");
        wr(ad(IDX_BIDIR_CFG), 8'h10);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            bidir_general_pin_i <= rnd[0];
            settle();
            rdc(ad(IDX_MONITOR), {rnd[0], 7'h00}, 1'b0);
        end
        $display("done: monitor");
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            s = (i < 8) ? 12'(i) : (i == 8) ? 12'hE00 : rnd[11:0];
            rnd = lfsr(rnd);
            wr(ad(IDX_SEL_A), {1'b0, s[2:0], 1'b0, s[5:3]});
            wr(ad(IDX_SEL_B), {1'b0, s[8:6], 1'b0, s[11:9]});
            input_pin_i <= (i < 8) ? 4'hF : rnd[3:0];
            settle();
            check({gpi_level, master_clock_in, daisy_chain_serial_in, pdm_data_in},
                exp_route(s, input_pin_i));
        end
        $display("done: input routing");
        finish_test();
    end
endmodule
